/* core/srp_defs.vh */
// Constants for the status reporting block: register offsets, field positions and reset values.
// Assumes an AHB-Lite master with 32-bit word accesses.
//
// Notes on behaviour
// - SRQ when enabled status bits 2,3,4,5,7 set.
// - ESE bit0 plus SRE bit5 signals operation complete.
// - Status bit 7 summarises enabled operation events.
// - Negative filter latches measuring bit falling edge.
// - Serial poll returns the status byte.
// - Parallel poll: enable AND status, ORed, inverted when PPC bit 3 is set.
// - Poll config selects data line and inversion.
// - Poll bit also readable without a poll.
// - Every status register part readable as number.
// - Error queue: push per error, pop per query.
// - Clear-status and power-on clear events and status.
// - Preset clears operation and questionable enables.
// - Preset fills positive filters, clears negative ones.
// - Only reset command alters instrument settings.
// - SRQ is the only unsolicited bus activity.
// - New command line clears the output buffer.
// - ESR bit0 set when commands before OPC finished.
`ifndef SRP_DEFS_VH
`define SRP_DEFS_VH
`define SRP_A_CMD      8'h00
`define SRP_A_STB      8'h04
`define SRP_A_SRE      8'h08
`define SRP_A_ESE      8'h0c
`define SRP_A_ESR      8'h10
`define SRP_A_PPE      8'h14
`define SRP_A_PPC      8'h18
`define SRP_A_IST      8'h1c
`define SRP_A_OPCOND   8'h20
`define SRP_A_OPEVT    8'h24
`define SRP_A_OPENA    8'h28
`define SRP_A_OPPTR    8'h2c
`define SRP_A_OPNTR    8'h30
`define SRP_A_QUCOND   8'h34
`define SRP_A_QUEVT    8'h38
`define SRP_A_QUENA    8'h3c
`define SRP_A_QUPTR    8'h40
`define SRP_A_QUNTR    8'h44
`define SRP_A_ERR      8'h48
`define SRP_C_CLS      0
`define SRP_C_SPRE     1
`define SRP_C_RST      2
`define SRP_C_OPC      3
`define SRP_C_NEWLINE  4
`define SRP_C_DCL      5
`define SRP_B_OPC      0
`define SRP_B_PON      7
`define SRP_B_EAV      2
`define SRP_B_QSUM     3
`define SRP_B_MAV      4
`define SRP_B_ESB      5
`define SRP_B_MSS      6
`define SRP_B_OSUM     7
`define SRP_SRQ_MASK   8'hbc
`define SRP_ESR_EXT    8'h7c
`define SRP_PTR_RST    16'hffff
`define SRP_NTR_RST    16'h0000
`define SRP_ENA_RST    16'h0000
`endif

/* core/srp_status.v */
// Status reporting core: status byte, service request, serial and parallel poll, error queue and resets.
// Assumes a single AHB-Lite master, word accesses only, and synchronous inputs on hclk.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "srp_defs.vh"
module srp_status #(
    parameter EQ_DEPTH = 8,
    parameter EQ_AW    = 3,
    parameter EQ_W     = 16
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              ce,
    input  wire              hsel,
    input  wire [7:0]        haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire              hready,
    input  wire [31:0]       hwdata,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    input  wire [15:0]       oper_cond,
    input  wire [15:0]       ques_cond,
    input  wire [7:0]        esr_event,
    input  wire              mav,
    input  wire              opc_done,
    input  wire              err_push,
    input  wire [EQ_W-1:0]   err_code,
    input  wire              dev_clear,
    input  wire              ppoll,
    output reg               srq,
    output reg  [7:0]        spoll_byte,
    output reg  [7:0]        pp_dout,
    output reg  [7:0]        pp_oe_n,
    output reg               obuf_clr,
    output reg               ibuf_abort,
    output reg               settings_rst
);
    reg  [7:0]      sre_r;
    reg  [7:0]      ese_r;
    reg  [7:0]      esr_r;
    reg  [7:0]      ppe_r;
    reg  [4:0]      ppc_r;
    reg  [15:0]     op_evt_r;
    reg  [15:0]     op_ena_r;
    reg  [15:0]     op_ptr_r;
    reg  [15:0]     op_ntr_r;
    reg  [15:0]     op_prev_r;
    reg  [15:0]     qu_evt_r;
    reg  [15:0]     qu_ena_r;
    reg  [15:0]     qu_ptr_r;
    reg  [15:0]     qu_ntr_r;
    reg  [15:0]     qu_prev_r;
    reg             opc_pend_r;
    reg             pon_r;
    reg  [EQ_W-1:0] eq_mem [0:EQ_DEPTH-1];
    reg  [EQ_AW-1:0] eq_rd_r;
    reg  [EQ_AW-1:0] eq_wr_r;
    reg  [EQ_AW:0]  eq_cnt_r;
    reg             dph_wr_r;
    reg  [7:0]      dph_addr_r;
    reg  [7:0]      stb;
    reg  [31:0]     rd_nxt;
    reg  [7:0]      esr_nxt;
    reg             ist;
    wire            acc      = hsel & htrans[1] & hready;
    wire            rd_acc   = acc & ~hwrite;
    wire            wr       = dph_wr_r;
    wire            cmd_wr   = wr & (dph_addr_r == `SRP_A_CMD);
    wire            cls      = cmd_wr & hwdata[`SRP_C_CLS];
    wire            spre     = cmd_wr & hwdata[`SRP_C_SPRE];
    wire            dcl      = dev_clear | (cmd_wr & hwdata[`SRP_C_DCL]);
    wire            eq_pop   = rd_acc & (haddr == `SRP_A_ERR) & (eq_cnt_r != {(EQ_AW+1){1'b0}});
    wire            eq_full  = (eq_cnt_r == EQ_DEPTH[EQ_AW:0]);
    // A full queue drops new entries so that the oldest causes stay visible.
    wire            eq_push  = err_push & ~eq_full & ~cls;
    wire            op_sum   = |(op_evt_r & op_ena_r);
    wire            qu_sum   = |(qu_evt_r & qu_ena_r);
    wire [15:0]     op_new   = (op_ptr_r & oper_cond & ~op_prev_r) | (op_ntr_r & ~oper_cond & op_prev_r);
    wire [15:0]     qu_new   = (qu_ptr_r & ques_cond & ~qu_prev_r) | (qu_ntr_r & ~ques_cond & qu_prev_r);
    wire            op_rdclr = rd_acc & (haddr == `SRP_A_OPEVT);
    wire            qu_rdclr = rd_acc & (haddr == `SRP_A_QUEVT);
    wire            esr_rdclr = rd_acc & (haddr == `SRP_A_ESR);
    wire            opc_fire = opc_pend_r & opc_done;

    // Only MSS depends on other status bits; bit 6 is still zero when the byte is read back,
    // so the request mask can never feed the summary into itself.
    always @* begin
        stb = 8'h00;
        stb[`SRP_B_EAV]  = (eq_cnt_r != {(EQ_AW+1){1'b0}});
        stb[`SRP_B_QSUM] = qu_sum;
        stb[`SRP_B_MAV]  = mav;
        stb[`SRP_B_ESB]  = |(esr_r & ese_r);
        stb[`SRP_B_OSUM] = op_sum;
        stb[`SRP_B_MSS]  = |(stb & sre_r & `SRP_SRQ_MASK);
        ist = |(ppe_r & stb);
    end

    // Event inputs are ORed in after a clearing read, so a new event in that cycle survives.
    always @* begin
        esr_nxt = esr_r & ~{8{esr_rdclr}};
        esr_nxt = esr_nxt | (esr_event & `SRP_ESR_EXT);
        if (opc_fire) begin
            esr_nxt[`SRP_B_OPC] = 1'b1;
        end
        if (pon_r) begin
            esr_nxt[`SRP_B_PON] = 1'b1;
        end
    end

    // Event reads and queue reads have side effects, so the word is taken once, at the address phase.
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (haddr)
            `SRP_A_STB:    rd_nxt = {24'h000000, stb};
            `SRP_A_SRE:    rd_nxt = {24'h000000, sre_r};
            `SRP_A_ESE:    rd_nxt = {24'h000000, ese_r};
            `SRP_A_ESR:    rd_nxt = {24'h000000, esr_r};
            `SRP_A_PPE:    rd_nxt = {24'h000000, ppe_r};
            `SRP_A_PPC:    rd_nxt = {27'h0000000, ppc_r};
            `SRP_A_IST:    rd_nxt = {31'h00000000, ist};
            `SRP_A_OPCOND: rd_nxt = {16'h0000, oper_cond};
            `SRP_A_OPEVT:  rd_nxt = {16'h0000, op_evt_r};
            `SRP_A_OPENA:  rd_nxt = {16'h0000, op_ena_r};
            `SRP_A_OPPTR:  rd_nxt = {16'h0000, op_ptr_r};
            `SRP_A_OPNTR:  rd_nxt = {16'h0000, op_ntr_r};
            `SRP_A_QUCOND: rd_nxt = {16'h0000, ques_cond};
            `SRP_A_QUEVT:  rd_nxt = {16'h0000, qu_evt_r};
            `SRP_A_QUENA:  rd_nxt = {16'h0000, qu_ena_r};
            `SRP_A_QUPTR:  rd_nxt = {16'h0000, qu_ptr_r};
            `SRP_A_QUNTR:  rd_nxt = {16'h0000, qu_ntr_r};
            `SRP_A_ERR:    rd_nxt = eq_pop ? {{(32-EQ_W){1'b0}}, eq_mem[eq_rd_r]} : 32'h0000_0000;
            default:       rd_nxt = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait states, read data registered at the address phase.
    // The ready and response outputs never change, so a master never waits and never sees an error.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
        end else if (ce) begin
            dph_wr_r   <= acc & hwrite;
            dph_addr_r <= haddr;
            if (rd_acc) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // Enable registers survive every reset except power-on.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sre_r <= 8'h00;
            ese_r <= 8'h00;
            ppe_r <= 8'h00;
            ppc_r <= 5'h00;
        end else if (ce && wr) begin
            case (dph_addr_r)
                `SRP_A_SRE: sre_r <= hwdata[7:0];
                `SRP_A_ESE: ese_r <= hwdata[7:0];
                `SRP_A_PPE: ppe_r <= hwdata[7:0];
                `SRP_A_PPC: ppc_r <= hwdata[4:0];
                default:    ppc_r <= ppc_r;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            esr_r      <= 8'h00;
            opc_pend_r <= 1'b0;
            pon_r      <= 1'b1;
            op_evt_r   <= 16'h0000;
            qu_evt_r   <= 16'h0000;
            op_prev_r  <= 16'h0000;
            qu_prev_r  <= 16'h0000;
        end else if (ce) begin
            pon_r     <= 1'b0;
            // Edges are found against last cycle's levels, so a pulse shorter than one clock is missed.
            // After reset the previous levels are zero, so a condition already high then counts as an edge.
            op_prev_r <= oper_cond;
            qu_prev_r <= ques_cond;
            if (cls) begin
                esr_r    <= 8'h00;
                op_evt_r <= 16'h0000;
                qu_evt_r <= 16'h0000;
            end else begin
                esr_r    <= esr_nxt;
                // New edges win over a clearing read in the same cycle.
                op_evt_r <= (op_evt_r & ~{16{op_rdclr}}) | op_new;
                qu_evt_r <= (qu_evt_r & ~{16{qu_rdclr}}) | qu_new;
            end
            if (cmd_wr && hwdata[`SRP_C_OPC]) begin
                opc_pend_r <= 1'b1;
            end else if (opc_fire || dcl) begin
                opc_pend_r <= 1'b0;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_ena_r <= `SRP_ENA_RST;
            qu_ena_r <= `SRP_ENA_RST;
            op_ptr_r <= `SRP_PTR_RST;
            op_ntr_r <= `SRP_NTR_RST;
            qu_ptr_r <= `SRP_PTR_RST;
            qu_ntr_r <= `SRP_NTR_RST;
        end else if (ce) begin
            // A preset wins over a register write that lands in the same cycle.
            if (spre) begin
                op_ena_r <= `SRP_ENA_RST;
                qu_ena_r <= `SRP_ENA_RST;
                op_ptr_r <= `SRP_PTR_RST;
                op_ntr_r <= `SRP_NTR_RST;
                qu_ptr_r <= `SRP_PTR_RST;
                qu_ntr_r <= `SRP_NTR_RST;
            end else if (wr) begin
                case (dph_addr_r)
                    `SRP_A_OPENA: op_ena_r <= hwdata[15:0];
                    `SRP_A_OPPTR: op_ptr_r <= hwdata[15:0];
                    `SRP_A_OPNTR: op_ntr_r <= hwdata[15:0];
                    `SRP_A_QUENA: qu_ena_r <= hwdata[15:0];
                    `SRP_A_QUPTR: qu_ptr_r <= hwdata[15:0];
                    `SRP_A_QUNTR: qu_ntr_r <= hwdata[15:0];
                    default:      qu_ntr_r <= qu_ntr_r;
                endcase
            end
        end
    end

    // The queue words have no reset; only entries below the count are ever read, so stale words never show.
    always @(posedge hclk) begin
        if (ce && eq_push) begin
            eq_mem[eq_wr_r] <= err_code;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eq_rd_r  <= {EQ_AW{1'b0}};
            eq_wr_r  <= {EQ_AW{1'b0}};
            eq_cnt_r <= {(EQ_AW+1){1'b0}};
        end else if (ce) begin
            // A clear-status command empties the queue and beats a push in the same cycle.
            if (cls) begin
                eq_rd_r  <= {EQ_AW{1'b0}};
                eq_wr_r  <= {EQ_AW{1'b0}};
                eq_cnt_r <= {(EQ_AW+1){1'b0}};
            end else begin
                if (eq_push) begin
                    eq_wr_r <= eq_wr_r + 1'b1;
                end
                if (eq_pop) begin
                    eq_rd_r <= eq_rd_r + 1'b1;
                end
                if (eq_push && !eq_pop) begin
                    eq_cnt_r <= eq_cnt_r + 1'b1;
                end else if (eq_pop && !eq_push) begin
                    eq_cnt_r <= eq_cnt_r - 1'b1;
                end
            end
        end
    end

    // Pins toward the bus and the command processor; only SRQ is unsolicited.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            srq          <= 1'b0;
            spoll_byte   <= 8'h00;
            pp_dout      <= 8'h00;
            pp_oe_n      <= 8'hff;
            // Reset holds both buffer strobes high, so power-on empties the buffers just as a device clear does.
            obuf_clr     <= 1'b1;
            ibuf_abort   <= 1'b1;
            settings_rst <= 1'b0;
        end else if (ce) begin
            srq          <= stb[`SRP_B_MSS];
            // The poll byte lags the status byte by one cycle, exactly as the request line does.
            spoll_byte   <= stb;
            pp_dout      <= 8'h00;
            pp_oe_n      <= 8'hff;
            // Only the assigned data line is driven; a poll with the enable bit clear leaves every line released.
            // Other devices answer on the other lines at the same time, so releasing them matters.
            if (ppoll && ppc_r[4]) begin
                pp_dout[ppc_r[2:0]] <= ist ^ ppc_r[3];
                pp_oe_n[ppc_r[2:0]] <= 1'b0;
            end
            obuf_clr     <= dcl | (cmd_wr & hwdata[`SRP_C_NEWLINE]);
            ibuf_abort   <= dcl;
            settings_rst <= cmd_wr & hwdata[`SRP_C_RST];
        end
    end
endmodule
`default_nettype wire

/* core/srp_unused_placeholder.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* tb/srp_ctl_model.sv */
// Bus controller model: runs parallel polls and resolves the eight data lines.
// Assumes the device's poll outputs; lines with no driver float high through pull-ups.
`timescale 1ns/100ps
`default_nettype none
module srp_ctl_model (
    input wire logic       hclk,
    input wire logic [7:0] pp_dout,
    input wire logic [7:0] pp_oe_n,
    output var logic       ppoll,
    output wire logic [7:0] dio
);
    assign dio = pp_oe_n | (~pp_oe_n & pp_dout);
    initial ppoll = 1'b0;
    // The poll is held for three edges so a device answering one edge late still settles.
    task automatic poll(output logic [7:0] resp);
        @(posedge hclk);
        ppoll <= 1'b1;
        repeat (3) @(posedge hclk);
        resp = dio;
        ppoll <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/srp_status_props.sv */
// Checker for the status reporting block: bus answer, service request and poll line relations.
// Assumes it is bound to srp_status and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "srp_defs.vh"
module srp_status_props #(
    parameter EQ_DEPTH = 8,
    parameter EQ_AW    = 3,
    parameter EQ_W     = 16
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       ce,
    input wire logic       hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       dev_clear,
    input wire logic       ppoll,
    input wire logic       srq,
    input wire logic [7:0] spoll_byte,
    input wire logic [7:0] pp_dout,
    input wire logic [7:0] pp_oe_n,
    input wire logic       obuf_clr,
    input wire logic       settings_rst
);
    // High in the data phase of a command word write, so pulses can be traced to their cause.
    logic cmd_wr_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_wr_r <= 1'b0;
        end else begin
            cmd_wr_r <= ce && hsel && htrans[1] && hready && hwrite && (haddr == `SRP_A_CMD);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    srq_mss_a: assert property (srq == spoll_byte[6]) else $error("srq differs from poll byte");
    srq_mask_a: assert property ((spoll_byte & 8'hbc) == 8'h00 |-> !srq) else $error("srq without cause");
    pp_idle_a: assert property (!ppoll [*2] |=> pp_oe_n == 8'hff && pp_dout == 8'h00)
        else $error("poll lines driven outside a poll");
    pp_one_a: assert property ($onehot0(~pp_oe_n)) else $error("more than one poll line driven");
    pp_quiet_a: assert property ((pp_dout & pp_oe_n) == 8'h00) else $error("undriven line data");
    dclr_flush_a: assert property (ce && dev_clear |=> obuf_clr) else $error("device clear kept buffer");
    rst_cause_a: assert property ($rose(settings_rst) |-> $past(cmd_wr_r) || $past(cmd_wr_r, 2))
        else $error("settings reset without command");
    obuf_cause_a: assert property ($rose(obuf_clr) |-> $past(dev_clear) || $past(cmd_wr_r) || $past(cmd_wr_r, 2))
        else $error("buffer clear without cause");
endmodule
bind srp_status srp_status_props #(.EQ_DEPTH(EQ_DEPTH), .EQ_AW(EQ_AW), .EQ_W(EQ_W)) u_srp_status_props (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .dev_clear,
    .ppoll, .srq, .spoll_byte, .pp_dout, .pp_oe_n, .obuf_clr, .settings_rst);
`default_nettype wire

/* tb/status_reporting_srq_poll_test.sv */
// Self-checking bench for the status reporting block over AHB-Lite with a controller model.
// Assumes srp_defs.vh on the include path; read results are checked from a queue by a monitor.
`timescale 1ns/100ps
`default_nettype none
`include "srp_defs.vh"
module status_reporting_srq_poll_test;
    logic        hclk, hresetn, ce, hsel, hwrite, mav, opc_done, err_push, dev_clear, rd_dp;
    logic        hreadyout, hresp, ppoll, srq, obuf_clr, ibuf_abort, settings_rst;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  haddr, esr_event, spoll_byte, pp_dout, pp_oe_n, dio, got;
    logic [15:0] oper_cond, ques_cond, err_code;
    logic [31:0] hwdata, hrdata;
    logic [31:0] exp_q[$];
    logic [7:0]  adr_q[$];
    logic [15:0] codes[3];
    int          failures, check_count, cycles, ln, ns, no, na;
    srp_status #(.EQ_DEPTH(8), .EQ_AW(3), .EQ_W(16)) i_srp_status (.hclk, .hresetn, .ce, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .oper_cond,
        .ques_cond, .esr_event, .mav, .opc_done, .err_push, .err_code, .dev_clear, .ppoll, .srq,
        .spoll_byte, .pp_dout, .pp_oe_n, .obuf_clr, .ibuf_abort, .settings_rst);
    srp_ctl_model i_srp_ctl_model (.hclk, .pp_dout, .pp_oe_n, .ppoll, .dio);
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One single transfer; for a read, d is the expected word handed to the monitor.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00; hwdata <= w ? d : 32'h0;
        if (!w) begin exp_q.push_back(d); adr_q.push_back(a); end
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic watch(input int n);
        ns = 0; no = 0; na = 0;
        repeat (n) begin
            @(posedge hclk);
            ns += (settings_rst === 1'b1); no += (obuf_clr === 1'b1); na += (ibuf_abort === 1'b1);
        end
    endtask
    task automatic filters;
        bus(0, `SRP_A_OPENA, 32'h0); bus(0, `SRP_A_QUENA, 32'h0);
        bus(0, `SRP_A_OPPTR, 32'hffff); bus(0, `SRP_A_QUPTR, 32'hffff);
        bus(0, `SRP_A_OPNTR, 32'h0); bus(0, `SRP_A_QUNTR, 32'h0);
    endtask
    always @(posedge hclk) begin
        if (rd_dp && hreadyout) chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), hrdata);
        rd_dp <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR run time expected below 20000 seen 20000");
            complete_run();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, mav, opc_done, err_push, dev_clear, rd_dp} = '0;
        ce = 1'b1; htrans = 2'b00; hsize = 3'b010; haddr = 8'h00; hwdata = 32'h0; esr_event = 8'h00;
        oper_cond = 16'h0; ques_cond = 16'h0; err_code = 16'h0; failures = 0; check_count = 0; cycles = 0;
        void'($urandom(36141));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, `SRP_A_ESR, 32'h80); bus(0, `SRP_A_ESR, 32'h0); bus(0, `SRP_A_STB, 32'h0);
        bus(0, `SRP_A_SRE, 32'h0); bus(0, `SRP_A_ESE, 32'h0); bus(0, `SRP_A_PPE, 32'h0);
        bus(0, `SRP_A_ERR, 32'h0); bus(0, 8'hfc, 32'h0); filters();
        bus(1, `SRP_A_SRE, 32'h10); ce <= 1'b0; mav <= 1'b1; repeat (3) @(posedge hclk);
        chk("frozen srq", 0, srq); ce <= 1'b1; repeat (3) @(posedge hclk);
        chk("srq", 1, srq); chk("poll byte", 32'h50, spoll_byte); bus(0, `SRP_A_STB, 32'h50);
        bus(1, `SRP_A_SRE, 32'h0); repeat (3) @(posedge hclk); chk("srq", 0, srq);
        mav <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            codes[i] = 16'($urandom_range(1, 16'hffff));
            @(posedge hclk); err_push <= 1'b1; err_code <= codes[i];
            @(posedge hclk); err_push <= 1'b0;
        end
        repeat (2) @(posedge hclk); bus(0, `SRP_A_STB, 32'h04);
        for (int i = 0; i < 3; i++) bus(0, `SRP_A_ERR, {16'h0, codes[i]});
        bus(0, `SRP_A_ERR, 32'h0);
        bus(1, `SRP_A_ESE, 32'h1); bus(1, `SRP_A_SRE, 32'h20); bus(1, `SRP_A_CMD, 32'h08);
        repeat (3) @(posedge hclk); chk("srq", 0, srq); opc_done <= 1'b1;
        repeat (3) @(posedge hclk); chk("srq", 1, srq); bus(0, `SRP_A_ESR, 32'h1);
        opc_done <= 1'b0; repeat (3) @(posedge hclk); chk("srq", 0, srq);
        bus(1, `SRP_A_OPPTR, 32'h0); bus(1, `SRP_A_OPNTR, 32'h10); bus(1, `SRP_A_OPENA, 32'h10);
        bus(1, `SRP_A_SRE, 32'h80); oper_cond <= 16'h0010; repeat (3) @(posedge hclk);
        chk("srq", 0, srq); oper_cond <= 16'h0; repeat (3) @(posedge hclk); chk("srq", 1, srq);
        bus(0, `SRP_A_OPEVT, 32'h10); bus(0, `SRP_A_OPCOND, 32'h0); bus(0, `SRP_A_OPEVT, 32'h0);
        mav <= 1'b1; bus(1, `SRP_A_SRE, 32'h10);
        for (int k = 0; k < 3; k++) begin
            ln = $urandom_range(0, 7);
            bus(1, `SRP_A_PPE, (k < 2) ? 32'h10 : 32'h0); bus(1, `SRP_A_PPC, 32'h10 | (k == 1) << 3 | ln);
            bus(0, `SRP_A_IST, (k < 2) ? 32'h1 : 32'h0);
            i_srp_ctl_model.poll(got);
            chk("poll enables", 8'(~(8'h01 << ln)), pp_oe_n);
            chk("poll lines", 8'(~(8'h01 << ln) | (8'(k == 0) << ln)), got);
            chk("srq with poll", 1, srq);
        end
        mav <= 1'b0; @(posedge hclk); esr_event <= 8'h20; @(posedge hclk); esr_event <= 8'h00;
        bus(1, `SRP_A_SRE, 32'h20); bus(1, `SRP_A_ESE, 32'h20); repeat (2) @(posedge hclk);
        chk("srq", 1, srq);
        bus(1, `SRP_A_CMD, 32'h01); bus(0, `SRP_A_ESR, 32'h0); bus(0, `SRP_A_STB, 32'h0);
        bus(1, `SRP_A_OPENA, 32'hffff); bus(1, `SRP_A_QUPTR, 32'h0); bus(1, `SRP_A_QUNTR, 32'hffff);
        bus(1, `SRP_A_CMD, 32'h02); filters(); bus(0, `SRP_A_ESE, 32'h20);
        ques_cond <= 16'h0008; repeat (2) @(posedge hclk); ques_cond <= 16'h0000;
        bus(0, `SRP_A_QUEVT, 32'h8);
        bus(1, `SRP_A_CMD, 32'h04); watch(4); chk("reset pulses", 1, ns); chk("abort", 0, na);
        @(posedge hclk); dev_clear <= 1'b1; @(posedge hclk); dev_clear <= 1'b0;
        watch(4); chk("clear settings", 0, ns); chk("clear flush", 1, no); chk("clear abort", 1, na);
        bus(1, `SRP_A_CMD, 32'h10); watch(4); chk("new line flush", 1, no);
        bus(0, `SRP_A_SRE, 32'h20); bus(0, `SRP_A_ESE, 32'h20); repeat (2) @(posedge hclk);
        @(posedge hclk); err_push <= 1'b1; @(posedge hclk); err_push <= 1'b0; hresetn <= 1'b0;
        repeat (3) @(posedge hclk); hresetn <= 1'b1;
        bus(0, `SRP_A_ESR, 32'h80); bus(0, `SRP_A_ERR, 32'h0); bus(0, `SRP_A_ESE, 32'h0);
        repeat (2) @(posedge hclk);
        complete_run();
    end
endmodule
`default_nettype wire
